// *** verilog/single_ended_path_defines.vh ***
`ifndef SINGLE_ENDED_PATH_DEFINES_VH
`define SINGLE_ENDED_PATH_DEFINES_VH

// ==========================================================
// Register offsets
`define PATH_CONTROL_ADDR      8'h2d
`define DIVIDER_A_ADDR         8'h2e
`define DIVIDER_B_ADDR         8'h2f
`define SOFT_RESET_ADDR        8'h30
`define PATH_STATUS_ADDR       8'h31

// ==========================================================
// Field positions in the path control and soft reset registers
`define SECOND_PRESCALE_MSB    7
`define SECOND_PRESCALE_LSB    6
`define FIRST_PRESCALE_MSB     5
`define FIRST_PRESCALE_LSB     4
`define SECOND_PIN_SEL_MSB     3
`define SECOND_PIN_SEL_LSB     2
`define FIRST_PIN_SEL_MSB      1
`define FIRST_PIN_SEL_LSB      0
`define SOFT_RESET_BIT         0

// ==========================================================
// Reset values
`define PATH_CONTROL_RESET     8'ha
`define DIVIDER_A_RESET        8'h00
`define DIVIDER_B_RESET        8'h00

// ==========================================================
// Encodings
`define PRESCALE_OFF           2'h0
`define PRESCALE_BY_FOUR       2'h1
`define PRESCALE_BY_FIVE       2'h2
`define PIN_FROM_DIVIDER_A     2'h0
`define PIN_FROM_DIVIDER_B     2'h1
`define PIN_NORMAL_STATUS      2'h2
`define PIN_DISABLED           2'h3

// ==========================================================
// Divide ratios
`define RATIO_OFF              9'h000
`define RATIO_FOUR             9'h004
`define RATIO_FIVE             9'h005
`define RATIO_FLOOR            9'h006
`define SETTING_FLOOR          8'h06

`endif

// *** verilog/tick_divider.v ***
`timescale 1ns/1ps
`include "single_ended_path_defines.vh"

// Divides a stream of input ticks by ratio_i; ratio zero holds the output low.
module tick_divider #(
  parameter RATIO_WIDTH = 9
) (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   rst_i,
  // Control
  input  wire [RATIO_WIDTH-1:0] ratio_i,
  input  wire                   restart_i,
  // Tick stream
  input  wire                   tick_i,
  output reg                    tick_o,
  output reg                    clk_o
);

  reg  [RATIO_WIDTH-1:0] count_reg;
  reg  [RATIO_WIDTH-1:0] count_next;
  wire                   running;
  wire [RATIO_WIDTH-1:0] half;

  assign running = (ratio_i != {RATIO_WIDTH{1'b0}});
  assign half    = ratio_i >> 1;

  always @* begin
    count_next = count_reg;
    if (!running || restart_i) begin
      count_next = {RATIO_WIDTH{1'b0}};
    end else if (tick_i) begin
      if (count_reg >= ratio_i - 1'b1) begin
        count_next = {RATIO_WIDTH{1'b0}};
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  // Output is a register so a disabled or restarted divider settles low without runt pulses
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= {RATIO_WIDTH{1'b0}};
      clk_o     <= 1'b0;
      tick_o    <= 1'b0;
    end else begin
      count_reg <= count_next;
      clk_o     <= running && !restart_i && (count_next < half);
      tick_o    <= running && !restart_i && tick_i && (count_next == {RATIO_WIDTH{1'b0}});
    end
  end

endmodule

// *** verilog/single_ended_path.v ***
`timescale 1ns/1ps
`include "single_ended_path_defines.vh"

// Function
// - Each indicator pin can carry the divider A or divider B clock, as chosen by its selector.
// - The dividers are fed from the single-ended prescalers of the first and second synthesizers.
// - The second prescale field at bits 7:6 decodes off, by 4, by 5, reserved, and resets to off.
// - The first prescale field at bits 5:4 decodes off, by 4, by 5, reserved, and resets to off.
// - The second pin selector at bits 3:2 picks divider A, divider B, status, or disabled; reset 2.
// - The first pin selector at bits 1:0 picks divider A, divider B, status, or disabled; reset 2.
// - Divider A is an 8-bit divider clocked from the first synthesizer's prescaler.
// - Divider A setting 0 is off, settings 1 to 5 divide by 6, and setting N above 5 divides by N+1.
// - The divider A setting resets to zero so divider A starts disabled.
// - Divider B is an 8-bit divider clocked from the second synthesizer's prescaler.
module single_ended_path (
  // Clock and reset
  input  wire       CLOCK_I,
  input  wire       SYS_RST_I,
  // Register port
  input  wire [7:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  // Synthesizer clocks, asynchronous to CLOCK_I
  input  wire       FIRST_SYNTH_CLK_I,
  input  wire       SECOND_SYNTH_CLK_I,
  // Normal status levels from logic on CLOCK_I
  input  wire       FIRST_STATUS_I,
  input  wire       SECOND_STATUS_I,
  // Indicator pins
  output reg        FIRST_INDICATOR_PIN_O,
  output reg        FIRST_INDICATOR_PIN_OE_O,
  output reg        SECOND_INDICATOR_PIN_O,
  output reg        SECOND_INDICATOR_PIN_OE_O
);

  // ==========================================================
  // Decoding helpers
  function [8:0] prescale_ratio;
    input [1:0] sel;
    begin
      case (sel)
        `PRESCALE_BY_FOUR: prescale_ratio = `RATIO_FOUR;
        `PRESCALE_BY_FIVE: prescale_ratio = `RATIO_FIVE;
        default:           prescale_ratio = `RATIO_OFF;
      endcase
    end
  endfunction

  function prescale_on;
    input [1:0] sel;
    begin
      prescale_on = (sel == `PRESCALE_BY_FOUR) || (sel == `PRESCALE_BY_FIVE);
    end
  endfunction

  function [8:0] divider_ratio;
    input [7:0] setting;
    begin
      if (setting == 8'h00) begin
        divider_ratio = `RATIO_OFF;
      end else if (setting < `SETTING_FLOOR) begin
        divider_ratio = `RATIO_FLOOR;
      end else begin
        divider_ratio = {1'b0, setting} + 9'h001;
      end
    end
  endfunction

  function [1:0] pin_drive;
    input [1:0] sel;
    input       clk_a;
    input       clk_b;
    input       status;
    begin
      case (sel)
        `PIN_FROM_DIVIDER_A: pin_drive = {clk_a, 1'b1};
        `PIN_FROM_DIVIDER_B: pin_drive = {clk_b, 1'b1};
        `PIN_NORMAL_STATUS:  pin_drive = {status, 1'b1};
        default:             pin_drive = 2'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // Registers
  reg  [7:0] path_control_reg;
  reg  [7:0] divider_a_reg;
  reg  [7:0] divider_b_reg;
  reg        stall_a_reg;
  reg        stall_b_reg;
  reg        soft_reset_reg;
  reg  [7:0] rdata_next;
  wire       clk_a;
  wire       clk_b;

  wire       wr_control  = WR_I && (ADDR_I == `PATH_CONTROL_ADDR);
  wire       wr_div_a    = WR_I && (ADDR_I == `DIVIDER_A_ADDR);
  wire       wr_div_b    = WR_I && (ADDR_I == `DIVIDER_B_ADDR);
  wire       wr_soft_rst = WR_I && (ADDR_I == `SOFT_RESET_ADDR) && WDATA_I[`SOFT_RESET_BIT];

  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      path_control_reg <= `PATH_CONTROL_RESET;
      divider_a_reg    <= `DIVIDER_A_RESET;
      divider_b_reg    <= `DIVIDER_B_RESET;
      stall_a_reg      <= 1'b0;
      stall_b_reg      <= 1'b0;
      soft_reset_reg   <= 1'b0;
    end else begin
      soft_reset_reg <= wr_soft_rst;
      if (wr_control) begin
        path_control_reg <= WDATA_I;
      end
      if (wr_div_a) begin
        divider_a_reg <= WDATA_I;
      end
      if (wr_div_b) begin
        divider_b_reg <= WDATA_I;
      end
      // A divider brought back from zero stays stopped until the channel soft reset
      if (wr_soft_rst) begin
        stall_a_reg <= 1'b0;
        stall_b_reg <= 1'b0;
      end else begin
        if (wr_div_a && WDATA_I == 8'h00) begin
          stall_a_reg <= 1'b1;
        end
        if (wr_div_b && WDATA_I == 8'h00) begin
          stall_b_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Read port: data stand only in the cycle after the strobe
  always @* begin
    rdata_next = 8'h00;
    case (ADDR_I)
      `PATH_CONTROL_ADDR: rdata_next = path_control_reg;
      `DIVIDER_A_ADDR:    rdata_next = divider_a_reg;
      `DIVIDER_B_ADDR:    rdata_next = divider_b_reg;
      `PATH_STATUS_ADDR:  rdata_next = {4'h0, clk_b, clk_a, stall_b_reg, stall_a_reg};
      default:            rdata_next = 8'h00;
    endcase
  end

  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= RD_I ? rdata_next : 8'h00;
    end
  end

  // ==========================================================
  // Synthesizer clock capture
  reg  [2:0] first_sync_reg;
  reg  [2:0] second_sync_reg;
  wire       first_edge  = first_sync_reg[1] && !first_sync_reg[2];
  wire       second_edge = second_sync_reg[1] && !second_sync_reg[2];

  // Limitation: synthesizer clocks must run below half of CLOCK_I to be counted
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      first_sync_reg  <= 3'h0;
      second_sync_reg <= 3'h0;
    end else begin
      first_sync_reg  <= {first_sync_reg[1:0], FIRST_SYNTH_CLK_I};
      second_sync_reg <= {second_sync_reg[1:0], SECOND_SYNTH_CLK_I};
    end
  end

  // ==========================================================
  // Prescalers and dividers
  wire       pre_a_tick;
  wire       pre_b_tick;
  wire [1:0] first_prescale_sel  = path_control_reg[`FIRST_PRESCALE_MSB:`FIRST_PRESCALE_LSB];
  wire [1:0] second_prescale_sel = path_control_reg[`SECOND_PRESCALE_MSB:`SECOND_PRESCALE_LSB];
  // A divider without prescaler ticks is stopped too, so its clock settles low instead of freezing high
  wire       stop_a  = stall_a_reg || !prescale_on(first_prescale_sel);
  wire       stop_b  = stall_b_reg || !prescale_on(second_prescale_sel);
  wire [8:0] ratio_a = stop_a ? `RATIO_OFF : divider_ratio(divider_a_reg);
  wire [8:0] ratio_b = stop_b ? `RATIO_OFF : divider_ratio(divider_b_reg);

  tick_divider #(.RATIO_WIDTH(9)) first_prescaler (
    .clk_i     (CLOCK_I),
    .rst_i     (SYS_RST_I),
    .ratio_i   (prescale_ratio(path_control_reg[`FIRST_PRESCALE_MSB:`FIRST_PRESCALE_LSB])),
    .restart_i (soft_reset_reg),
    .tick_i    (first_edge),
    .tick_o    (pre_a_tick),
    .clk_o     ()
  );

  tick_divider #(.RATIO_WIDTH(9)) second_prescaler (
    .clk_i     (CLOCK_I),
    .rst_i     (SYS_RST_I),
    .ratio_i   (prescale_ratio(path_control_reg[`SECOND_PRESCALE_MSB:`SECOND_PRESCALE_LSB])),
    .restart_i (soft_reset_reg),
    .tick_i    (second_edge),
    .tick_o    (pre_b_tick),
    .clk_o     ()
  );

  tick_divider #(.RATIO_WIDTH(9)) divider_a (
    .clk_i     (CLOCK_I),
    .rst_i     (SYS_RST_I),
    .ratio_i   (ratio_a),
    .restart_i (soft_reset_reg),
    .tick_i    (pre_a_tick),
    .tick_o    (),
    .clk_o     (clk_a)
  );

  tick_divider #(.RATIO_WIDTH(9)) divider_b (
    .clk_i     (CLOCK_I),
    .rst_i     (SYS_RST_I),
    .ratio_i   (ratio_b),
    .restart_i (soft_reset_reg),
    .tick_i    (pre_b_tick),
    .tick_o    (),
    .clk_o     (clk_b)
  );

  // ==========================================================
  // Indicator pin routing
  wire [1:0] first_drive  = pin_drive(path_control_reg[`FIRST_PIN_SEL_MSB:`FIRST_PIN_SEL_LSB],
                                      clk_a, clk_b, FIRST_STATUS_I);
  wire [1:0] second_drive = pin_drive(path_control_reg[`SECOND_PIN_SEL_MSB:`SECOND_PIN_SEL_LSB],
                                      clk_a, clk_b, SECOND_STATUS_I);

  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      FIRST_INDICATOR_PIN_O     <= 1'b0;
      FIRST_INDICATOR_PIN_OE_O  <= 1'b0;
      SECOND_INDICATOR_PIN_O    <= 1'b0;
      SECOND_INDICATOR_PIN_OE_O <= 1'b0;
    end else begin
      FIRST_INDICATOR_PIN_O     <= first_drive[1];
      FIRST_INDICATOR_PIN_OE_O  <= first_drive[0];
      SECOND_INDICATOR_PIN_O    <= second_drive[1];
      SECOND_INDICATOR_PIN_OE_O <= second_drive[0];
    end
  end

endmodule

// *** dv/single_ended_path_sva.sv ***
`timescale 1ns/1ps
// ==========================================
// Port checks
module single_ended_path_sva (
  // Clock and reset
  input wire       CLOCK_I,
  input wire       SYS_RST_I,
  // Register port
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [7:0] RDATA_O,
  // Status and pins
  input wire       FIRST_STATUS_I,
  input wire       SECOND_STATUS_I,
  input wire       FIRST_INDICATOR_PIN_O,
  input wire       FIRST_INDICATOR_PIN_OE_O,
  input wire       SECOND_INDICATOR_PIN_O,
  input wire       SECOND_INDICATOR_PIN_OE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  wire ctl_wr = WR_I && ADDR_I == 8'h2d;
  property p_rdata_idle; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_ctl_back; ctl_wr ##1 !WR_I ##1 (RD_I && ADDR_I == 8'h2d) |=> RDATA_O == $past(WDATA_I, 3); endproperty
  a_ctl_back: assert property (p_ctl_back) else $error("control readback wrong");
  property p_div_back; WR_I && ADDR_I == 8'h2e ##1 !WR_I ##1 (RD_I && ADDR_I == 8'h2e) |=>
    RDATA_O == $past(WDATA_I, 3); endproperty
  a_div_back: assert property (p_div_back) else $error("divider readback wrong");
  property p_first_off; ctl_wr && WDATA_I[1:0] == 2'h3 ##1 !WR_I |=>
    !FIRST_INDICATOR_PIN_OE_O && !FIRST_INDICATOR_PIN_O; endproperty
  a_first_off: assert property (p_first_off) else $error("first pin not disabled");
  property p_second_off; ctl_wr && WDATA_I[3:2] == 2'h3 ##1 !WR_I |=>
    !SECOND_INDICATOR_PIN_OE_O && !SECOND_INDICATOR_PIN_O; endproperty
  a_second_off: assert property (p_second_off) else $error("second pin not disabled");
  property p_first_stat; ctl_wr && WDATA_I[1:0] == 2'h2 ##1 !WR_I |=>
    FIRST_INDICATOR_PIN_OE_O && FIRST_INDICATOR_PIN_O == $past(FIRST_STATUS_I); endproperty
  a_first_stat: assert property (p_first_stat) else $error("first pin not status");
  property p_second_stat; ctl_wr && WDATA_I[3:2] == 2'h2 ##1 !WR_I |=>
    SECOND_INDICATOR_PIN_OE_O && SECOND_INDICATOR_PIN_O == $past(SECOND_STATUS_I); endproperty
  a_second_stat: assert property (p_second_stat) else $error("second pin not status");
  property p_stall; WR_I && ADDR_I == 8'h2e && WDATA_I == 8'h00 ##2 (RD_I && ADDR_I == 8'h31) |=> RDATA_O[0];
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag not set");
  property p_restart; WR_I && ADDR_I == 8'h30 && WDATA_I[0] ##1 !WR_I ##1 (RD_I && ADDR_I == 8'h31) |=> !RDATA_O[0];
  endproperty
  a_restart: assert property (p_restart) else $error("stall flag not cleared");
endmodule
bind single_ended_path single_ended_path_sva u_single_ended_path_sva (.*);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench
module testbench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, s1 = 0, s2 = 0, fs = 0, ss = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  wire p1, oe1, p2, oe2;
  integer err_count = 0, check_count = 0;
  always #4 clk = ~clk;
  // Synth clocks are slow multiples of the system clock so periods count exactly
  always #32 s1 = ~s1;
  always #40 s2 = ~s2;
  single_ended_path u_single_ended_path (.CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FIRST_SYNTH_CLK_I(s1), .SECOND_SYNTH_CLK_I(s2),
    .FIRST_STATUS_I(fs), .SECOND_STATUS_I(ss), .FIRST_INDICATOR_PIN_O(p1), .FIRST_INDICATOR_PIN_OE_O(oe1),
    .SECOND_INDICATOR_PIN_O(p2), .SECOND_INDICATOR_PIN_OE_O(oe2));
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr8(input [7:0] a, input [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd8(input [7:0] a, output [7:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Skips two rising edges so a ratio change has settled before timing
  task measure(input bit second, input [31:0] per_e, input [31:0] hi_e);
    integer n, per, hi, edges;
    logic prev, cur;
    per = 0; hi = 0; edges = 0; prev = 1'b1;
    for (n = 0; n < 40000 && edges < 4; n++) begin
      @(posedge clk); #1 cur = second ? p2 : p1;
      if (cur === 1'b1 && prev === 1'b0) edges++;
      if (edges == 3) begin per++; hi += (cur === 1'b1); end
      prev = cur;
    end
    check("period", per, per_e);
    check("high", hi, hi_e);
  endtask
  task quiet(input bit second);
    integer n, moved;
    moved = 0;
    repeat (20) @(posedge clk);
    for (n = 0; n < 400; n++) begin @(posedge clk); #1 moved += ((second ? p2 : p1) !== 1'b0); end
    check("static pin", moved, 0);
  endtask
  task t_reset_values;
    rd8(8'h2d, d); check("control", d, 8'h0a);
    rd8(8'h2e, d); check("divider a", d, 8'h00);
    rd8(8'h2f, d); check("divider b", d, 8'h00);
    wr8(8'h40, 8'h5a); rd8(8'h40, d); check("unmapped", d, 8'h00);
    wr8(8'h2e, 8'h5a); rd8(8'h2e, d); check("divider a rw", d, 8'h5a);
    wr8(8'h2d, 8'h9b); rd8(8'h2d, d); check("control rw", d, 8'h9b);
  endtask
  task t_status;
    @(posedge clk); fs <= 1'b1; ss <= 1'b0;
    wr8(8'h2d, 8'h0a); repeat (2) @(posedge clk); #1 check("status pins", {p1, oe1, p2, oe2}, 4'b1101);
    fs <= 1'b0; ss <= 1'b1;
    repeat (3) @(posedge clk); #1 check("status flip", {p1, oe1, p2, oe2}, 4'b0111);
    wr8(8'h2d, 8'h0f); repeat (2) @(posedge clk); #1 check("disabled", {p1, oe1, p2, oe2}, 4'b0000);
  endtask
  task divide_case(input [7:0] ctl, input [7:0] a, input [7:0] b, input bit second, input [31:0] per, input [31:0] hi);
    wr8(8'h2e, a); wr8(8'h2f, b); wr8(8'h2d, ctl);
    measure(second, per, hi);
    check("pin enable", second ? oe2 : oe1, 1'b1);
  endtask
  task t_divide;
    divide_case(8'h10, 8'h06, 8'h07, 0, 224, 96);
    divide_case(8'h20, 8'h01, 8'h07, 1, 240, 120);
    divide_case(8'h10, 8'hff, 8'h07, 0, 8192, 4096);
    divide_case(8'h45, 8'h06, 8'h07, 0, 320, 160);
    divide_case(8'h85, 8'h06, 8'h05, 1, 300, 150);
  endtask
  task t_prescale_off;
    wr8(8'h2d, 8'h00); quiet(0);
    wr8(8'h2d, 8'h30); quiet(0);
    wr8(8'h2d, 8'hc5); quiet(1);
  endtask
  task t_stall;
    wr8(8'h2d, 8'h10); wr8(8'h2f, 8'h00);
    wr8(8'h2e, 8'h00); rd8(8'h31, d); check("stalled", d[1:0], 2'b11);
    wr8(8'h2e, 8'h06); quiet(0);
    wr8(8'h30, 8'h01); rd8(8'h31, d); check("restarted", d[1:0], 2'b00);
    measure(0, 224, 96);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset_values;
    t_status;
    t_divide;
    t_prescale_off;
    t_stall;
    report_and_stop;
  end
  // Expected run is about 40k cycles
  initial begin
    #640000;
    err_count++;
    report_and_stop;
  end
endmodule
